// ===== hdl/nvs_pkg.sv
/*
  Shared constants for the nonvolatile word store: map, command codes, frame
  fields, wiper codes and the code arithmetic of the halving and doubling steps.
  Assumes one clock domain and a 24-bit serial command frame.
*/
package nvs_pkg;
  localparam int WORD_W = 16;
  localparam int WIPER_W = 10;
  localparam int ADDR_W = 4;
  localparam int CMD_W = 4;
  localparam int FRAME_W = 24;
  localparam int WORDS = 16;
  localparam int CNT_W = 5;

  localparam int CMD_MSB = 23;
  localparam int CMD_LSB = 20;
  localparam int ADDR_MSB = 19;
  localparam int ADDR_LSB = 16;
  localparam int DATA_MSB = 15;
  localparam int SEL_BIT = 16;

  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h18;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

  localparam logic [ADDR_W-1:0] ADDR_PRESET1 = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_PRESET2 = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_USER_FIRST = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_USER_SECOND = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_USER_LAST = 4'he;
  localparam logic [ADDR_W-1:0] ADDR_TOLERANCE = 4'hf;

  localparam logic [CMD_W-1:0] CMD_NOP = 4'h0;
  localparam logic [CMD_W-1:0] CMD_RESTORE = 4'h1;
  localparam logic [CMD_W-1:0] CMD_SAVE_WIPER = 4'h2;
  localparam logic [CMD_W-1:0] CMD_WRITE_STORE = 4'h3;
  localparam logic [CMD_W-1:0] CMD_HALVE = 4'h4;
  localparam logic [CMD_W-1:0] CMD_HALVE_ALL = 4'h5;
  localparam logic [CMD_W-1:0] CMD_RESTORE_ALL = 4'h8;
  localparam logic [CMD_W-1:0] CMD_READ_STORE = 4'h9;
  localparam logic [CMD_W-1:0] CMD_WRITE_WIPER = 4'hb;
  localparam logic [CMD_W-1:0] CMD_DOUBLE = 4'hc;
  localparam logic [CMD_W-1:0] CMD_DOUBLE_ALL = 4'hd;

  localparam logic [WIPER_W-1:0] WIPER_ZERO = 10'h000;
  localparam logic [WIPER_W-1:0] WIPER_ONE = 10'h001;
  localparam logic [WIPER_W-1:0] WIPER_MID = 10'h200;
  localparam logic [WIPER_W-1:0] WIPER_FULL = 10'h3ff;

  localparam logic [WORD_W-1:0] PRESET_RESET = 16'h0200;
  localparam logic [WORD_W-1:0] USER_RESET = 16'h0000;

  localparam int TOL_SIGN_BIT = 15;
  localparam int TOL_INT_W = 7;
  localparam int TOL_FRAC_W = 8;

  localparam int PIN_CS = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_SDI = 2;
  localparam int PIN_PRESET = 3;
  localparam int PIN_COUNT = 4;
  localparam logic [PIN_COUNT-1:0] PIN_IDLE = 4'h9;

  typedef enum logic [0:0] {NVS_ST_BOOT = 1'b0, NVS_ST_RUN = 1'b1} nvs_state_t;

  function automatic logic [WIPER_W-1:0] nvs_halve(input logic [WIPER_W-1:0] code);
    nvs_halve = code >> 1;
  endfunction

  function automatic logic [WIPER_W-1:0] nvs_double(input logic [WIPER_W-1:0] code);
    if (code == WIPER_ZERO)
    begin
      nvs_double = WIPER_ONE;
    end
    else if (code >= WIPER_MID)
    begin
      nvs_double = WIPER_FULL;
    end
    else
    begin
      nvs_double = code << 1;
    end
  endfunction
endpackage

// ===== hdl/nvs_store.sv
/*
  Sixteen-word store held in flip-flops, with one write port, one read port and
  both channel presets always visible. Assumes writes come from the command
  decoder on the same clock; the tolerance word is fixed at build time.
*/
`timescale 1ns/1ps
module nvs_store
  import nvs_pkg::*;
#(
  parameter logic TOL_SIGN = 1'b0,
  parameter logic [TOL_INT_W-1:0] TOL_INT = 7'h00,
  parameter logic [TOL_FRAC_W-1:0] TOL_FRAC = 8'h00
)
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic we_in,
  input wire logic [ADDR_W-1:0] waddr_in,
  input wire logic [WORD_W-1:0] wdata_in,
  input wire logic [ADDR_W-1:0] raddr_in,
  output logic [WORD_W-1:0] rdata_out,
  output logic [WORD_W-1:0] preset1_out,
  output logic [WORD_W-1:0] preset2_out
);
  // Sign, integer percent, fraction
  localparam logic [WORD_W-1:0] TOL_WORD = {TOL_SIGN, TOL_INT, TOL_FRAC};

  logic [WORD_W-1:0] mem [WORDS];
  logic [WORD_W-1:0] next_mem [WORDS];

  always_comb
  begin
    next_mem = mem;
    // Factory word cannot be overwritten
    if (we_in && (waddr_in != ADDR_TOLERANCE))
    begin
      next_mem[waddr_in] = wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int i = 0; i < WORDS; i++)
      begin
        if (i == int'(ADDR_PRESET1) || i == int'(ADDR_PRESET2))
        begin
          mem[i] <= PRESET_RESET;
        end
        else if (i == int'(ADDR_TOLERANCE))
        begin
          mem[i] <= TOL_WORD;
        end
        else
        begin
          mem[i] <= USER_RESET;
        end
      end
    end
    else
    begin
      mem <= next_mem;
    end
  end

  assign rdata_out = mem[raddr_in];
  assign preset1_out = mem[ADDR_PRESET1];
  assign preset2_out = mem[ADDR_PRESET2];

  property p_tol_fixed;
    @(posedge clk_in) disable iff (!rst_b_in)
      mem[ADDR_TOLERANCE] == TOL_WORD;
  endproperty
  a_tol_fixed: assert property (p_tol_fixed) else $error("tolerance word changed");

  property p_user_write;
    @(posedge clk_in) disable iff (!rst_b_in)
      we_in && (waddr_in != ADDR_TOLERANCE) |=> mem[$past(waddr_in)] == $past(wdata_in);
  endproperty
  a_user_write: assert property (p_user_write) else $error("store write lost");
endmodule

// ===== hdl/nvs_top.sv
/*
  Serial-command front end of the dual-channel wiper device: pin sampling,
  24-bit frame capture, command execution, wiper registers and read-back.
  Assumes a mode-0 host (sample on rising serial clock) much slower than CLK_IN.
*/
`timescale 1ns/1ps
module nvs_top
  import nvs_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic SPI_CS_B_IN,
  input wire logic SPI_SCLK_IN,
  input wire logic SPI_SDI_IN,
  input wire logic PRESET_PIN_B_IN,
  output logic SPI_SDO_OUT,
  output logic SPI_SDO_OE_OUT,
  output logic [WIPER_W-1:0] WIPER1_OUT,
  output logic [WIPER_W-1:0] WIPER2_OUT,
  output logic READ_POWER_OUT
);
  logic [PIN_COUNT-1:0] raw, s1, s2, s3, flt, flt_d, next_flt;
  nvs_state_t state, next_state;
  logic [FRAME_W-1:0] rx, next_rx, sdo_shift, next_sdo_shift;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [WIPER_W-1:0] wiper1, next_wiper1, wiper2, next_wiper2;
  logic read_power, next_read_power;
  logic cs_low, cs_rise, cs_fall, sclk_rise, sclk_fall, pin_fall, pin_rise, exec;
  logic [CMD_W-1:0] cmd;
  logic [ADDR_W-1:0] addr;
  logic [WORD_W-1:0] data;
  logic st_we;
  logic [WORD_W-1:0] rd_data, preset1, preset2;
  logic [WIPER_W-1:0] preset1_code, preset2_code;

  // Three stages; a level is accepted only when stages two and three agree
  assign raw = {PRESET_PIN_B_IN, SPI_SDI_IN, SPI_SCLK_IN, SPI_CS_B_IN};

  always_comb
  begin
    next_flt = (~(s2 ^ s3) & s2) | ((s2 ^ s3) & flt);
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      s1 <= PIN_IDLE;
      s2 <= PIN_IDLE;
      s3 <= PIN_IDLE;
      flt <= PIN_IDLE;
      flt_d <= PIN_IDLE;
    end
    else
    begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      flt <= next_flt;
      flt_d <= flt;
    end
  end

  assign cs_low = ~flt[PIN_CS];
  assign cs_rise = flt[PIN_CS] & ~flt_d[PIN_CS];
  assign cs_fall = ~flt[PIN_CS] & flt_d[PIN_CS];
  assign sclk_rise = flt[PIN_SCLK] & ~flt_d[PIN_SCLK];
  assign sclk_fall = ~flt[PIN_SCLK] & flt_d[PIN_SCLK];
  assign pin_fall = ~flt[PIN_PRESET] & flt_d[PIN_PRESET];
  assign pin_rise = flt[PIN_PRESET] & ~flt_d[PIN_PRESET];

  assign cmd = rx[CMD_MSB:CMD_LSB];
  assign addr = rx[ADDR_MSB:ADDR_LSB];
  assign data = rx[DATA_MSB:0];
  // Short frames are dropped; longer ones keep the last 24 bits for chaining
  assign exec = cs_rise && (cnt == FRAME_BITS) && (state == NVS_ST_RUN);
  assign preset1_code = preset1[WIPER_W-1:0];
  assign preset2_code = preset2[WIPER_W-1:0];

  nvs_store u_store (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .we_in(st_we),
    .waddr_in(addr),
    .wdata_in((cmd == CMD_SAVE_WIPER) ? {{(WORD_W-WIPER_W){1'b0}},
               (addr == ADDR_PRESET1) ? wiper1 : wiper2} : data),
    .raddr_in(addr),
    .rdata_out(rd_data),
    .preset1_out(preset1),
    .preset2_out(preset2)
  );

  always_comb
  begin
    next_state = state;
    next_rx = rx;
    next_cnt = cnt;
    next_sdo_shift = sdo_shift;
    next_wiper1 = wiper1;
    next_wiper2 = wiper2;
    next_read_power = read_power;
    st_we = 1'b0;
    if (cs_fall)
    begin
      next_cnt = CNT_ZERO;
    end
    else if (cs_low && sclk_rise)
    begin
      next_rx = {rx[FRAME_W-2:0], flt[PIN_SDI]};
      if (cnt != FRAME_BITS)
      begin
        next_cnt = cnt + CNT_ONE;
      end
    end
    if (cs_low && sclk_fall)
    begin
      next_sdo_shift = {sdo_shift[FRAME_W-2:0], 1'b0};
    end
    case (state)
      NVS_ST_BOOT:
      begin
        next_wiper1 = preset1_code;
        next_wiper2 = preset2_code;
        next_state = NVS_ST_RUN;
      end
      NVS_ST_RUN:
      begin
        if (cs_rise)
        begin
          // Otherwise pass the frame on toward the next chained device
          next_sdo_shift = rx;
        end
        if (exec)
        begin
          case (cmd)
            CMD_NOP:
            begin
              next_read_power = 1'b0;
            end
            CMD_RESTORE:
            begin
              next_read_power = 1'b1;
              if (rx[SEL_BIT])
              begin
                next_wiper2 = preset2_code;
              end
              else
              begin
                next_wiper1 = preset1_code;
              end
            end
            CMD_RESTORE_ALL:
            begin
              next_wiper1 = preset1_code;
              next_wiper2 = preset2_code;
            end
            CMD_SAVE_WIPER:
            begin
              st_we = (addr == ADDR_PRESET1) || (addr == ADDR_PRESET2);
            end
            CMD_WRITE_STORE:
            begin
              st_we = 1'b1;
            end
            CMD_READ_STORE:
            begin
              next_sdo_shift = {cmd, addr, rd_data};
            end
            CMD_WRITE_WIPER:
            begin
              if (rx[SEL_BIT])
              begin
                next_wiper2 = data[WIPER_W-1:0];
              end
              else
              begin
                next_wiper1 = data[WIPER_W-1:0];
              end
            end
            CMD_HALVE, CMD_HALVE_ALL:
            begin
              // Odd codes lose their low bit; only even codes step exactly
              if (cmd == CMD_HALVE_ALL || !rx[SEL_BIT])
              begin
                next_wiper1 = nvs_halve(wiper1);
              end
              if (cmd == CMD_HALVE_ALL || rx[SEL_BIT])
              begin
                next_wiper2 = nvs_halve(wiper2);
              end
            end
            CMD_DOUBLE, CMD_DOUBLE_ALL:
            begin
              if (cmd == CMD_DOUBLE_ALL || !rx[SEL_BIT])
              begin
                next_wiper1 = nvs_double(wiper1);
              end
              if (cmd == CMD_DOUBLE_ALL || rx[SEL_BIT])
              begin
                next_wiper2 = nvs_double(wiper2);
              end
            end
            default:
            begin
              next_read_power = read_power;
            end
          endcase
        end
        // The pin overrides the wiper result of any command finishing in the same cycle
        if (pin_fall)
        begin
          next_wiper1 = WIPER_MID;
          next_wiper2 = WIPER_MID;
        end
        else if (pin_rise)
        begin
          next_wiper1 = preset1_code;
          next_wiper2 = preset2_code;
        end
      end
      default:
      begin
        next_state = NVS_ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      state <= NVS_ST_BOOT;
      rx <= '0;
      cnt <= CNT_ZERO;
      sdo_shift <= '0;
      wiper1 <= WIPER_MID;
      wiper2 <= WIPER_MID;
      read_power <= 1'b0;
    end
    else
    begin
      state <= next_state;
      rx <= next_rx;
      cnt <= next_cnt;
      sdo_shift <= next_sdo_shift;
      wiper1 <= next_wiper1;
      wiper2 <= next_wiper2;
      read_power <= next_read_power;
    end
  end

  // Open drain: only ever pulls low, and only while selected
  assign SPI_SDO_OUT = 1'b0;
  assign SPI_SDO_OE_OUT = cs_low & ~sdo_shift[FRAME_W-1];
  assign WIPER1_OUT = wiper1;
  assign WIPER2_OUT = wiper2;
  assign READ_POWER_OUT = read_power;

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  property p_boot;
    state == NVS_ST_BOOT |=> wiper1 == $past(preset1_code) && wiper2 == $past(preset2_code);
  endproperty
  a_boot: assert property (p_boot) else $error("boot restore missed");

  property p_restore_all;
    exec && cmd == CMD_RESTORE_ALL && !pin_fall && !pin_rise
      |=> wiper1 == preset1[WIPER_W-1:0] && wiper2 == preset2[WIPER_W-1:0];
  endproperty
  a_restore_all: assert property (p_restore_all) else $error("restore all missed");

  property p_pin_restore;
    state == NVS_ST_RUN && pin_rise
      |=> wiper1 == $past(preset1_code) && wiper2 == $past(preset2_code);
  endproperty
  a_pin_restore: assert property (p_pin_restore) else $error("pin restore missed");

  property p_read_power_on;
    exec && cmd == CMD_RESTORE |=> read_power;
  endproperty
  a_read_power_on: assert property (p_read_power_on) else $error("read power not set");

  property p_read_power_hold;
    read_power && !(exec && cmd == CMD_NOP) |=> read_power;
  endproperty
  a_read_power_hold: assert property (p_read_power_hold) else $error("read power left");

  property p_halve;
    exec && cmd == CMD_HALVE_ALL && !pin_fall && !pin_rise
      |=> wiper1 == ($past(wiper1) >> 1) && wiper2 == ($past(wiper2) >> 1);
  endproperty
  a_halve: assert property (p_halve) else $error("halve wrong");

  property p_double_zero;
    exec && cmd == CMD_DOUBLE_ALL && wiper1 == WIPER_ZERO && !pin_fall && !pin_rise
      |=> wiper1 == WIPER_ONE;
  endproperty
  a_double_zero: assert property (p_double_zero) else $error("zero doubling wrong");

  property p_double_full;
    exec && cmd == CMD_DOUBLE_ALL && wiper2 >= WIPER_MID && !pin_fall && !pin_rise
      |=> wiper2 == WIPER_FULL;
  endproperty
  a_double_full: assert property (p_double_full) else $error("saturation wrong");

  property p_store_keeps_wiper;
    exec && (cmd == CMD_WRITE_STORE || cmd == CMD_READ_STORE) && !pin_fall && !pin_rise
      |=> $stable(wiper1) && $stable(wiper2);
  endproperty
  a_store_keeps_wiper: assert property (p_store_keeps_wiper) else $error("wiper moved");

  property p_read_load;
    exec && cmd == CMD_READ_STORE |=> sdo_shift[DATA_MSB:0] == $past(rd_data);
  endproperty
  a_read_load: assert property (p_read_load) else $error("read word not loaded");

  property p_sdo_idle;
    flt[PIN_CS] |-> !SPI_SDO_OE_OUT;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("drive while deselected");

  c_read: cover property (exec && cmd == CMD_READ_STORE ##[1:1000] cs_fall);
  c_restore_nop: cover property (exec && cmd == CMD_RESTORE ##[1:1000] exec && cmd == CMD_NOP);
  c_double_sat: cover property (exec && cmd == CMD_DOUBLE && wiper1 >= WIPER_MID);
  c_pin_pulse: cover property (pin_fall ##[1:1000] pin_rise);
endmodule

// ===== tb/nvs_host.sv
/*
  Host controller model on the serial command link: mode-0 frames, MSB first.
  Assumes a pulled-up open-drain data return and a 250 MHz reference clock.
*/
`timescale 1ns/1ps
module nvs_host
(
  input wire logic clk_in,
  input wire logic sdo_in,
  output logic cs_b_out,
  output logic sclk_out,
  output logic sdi_out,
  output logic done_out,
  output logic [23:0] rx_out
);
  // Slow edges so the pin filters inside the device always settle
  localparam int HALF = 10;

  initial
  begin
    cs_b_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
    done_out = 1'b0;
    rx_out = 24'h00_0000;
  end

  task automatic frame(input logic [23:0] w, input int n);
    int i;
    @(negedge clk_in);
    cs_b_out = 1'b0;
    for (i = 0; i < n; i++)
    begin
      sdi_out = w[23-i];
      repeat (HALF) @(negedge clk_in);
      rx_out = {rx_out[22:0], sdo_in};
      sclk_out = 1'b1;
      repeat (HALF) @(negedge clk_in);
      sclk_out = 1'b0;
    end
    repeat (HALF) @(negedge clk_in);
    cs_b_out = 1'b1;
    // Released line shows the inverse so a stale bit is never reused
    sdi_out = ~sdi_out;
    repeat (12) @(negedge clk_in);
    done_out = 1'b1;
    @(negedge clk_in);
    done_out = 1'b0;
  endtask
endmodule

// ===== tb/nvs_top_bench.sv
/*
  Self-checking bench for the wiper device: host model drives frames, a
  monitor compares wipers, power state and read-back against queued notes.
  Assumes the design's open-drain data pin needs an external pull-up.
*/
`timescale 1ns/1ps
module nvs_top_bench;
  import nvs_pkg::*;

  typedef struct {
    logic chk;
    logic [23:0] rx;
    logic [WIPER_W-1:0] w1;
    logic [WIPER_W-1:0] w2;
    logic rp;
  } nvs_exp_t;

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic preset_b = 1'b1;
  logic cs_b;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic sdo_wire;
  logic done;
  logic [23:0] rx;
  logic [WIPER_W-1:0] wiper1;
  logic [WIPER_W-1:0] wiper2;
  logic read_power;
  logic [WIPER_W-1:0] e_w1 = WIPER_MID;
  logic [WIPER_W-1:0] e_w2 = WIPER_MID;
  logic e_rp = 1'b0;
  nvs_exp_t exp_q[$];
  int bad_count = 0;
  int checks_done = 0;
  int seed = 32'h1e16;

  assign sdo_wire = sdo_oe ? sdo : 1'b1;

  initial
  begin
    forever #2 clk = ~clk;
  end

  nvs_top dut (
    .CLK_IN(clk),
    .RST_B_IN(rst_b),
    .SPI_CS_B_IN(cs_b),
    .SPI_SCLK_IN(sclk),
    .SPI_SDI_IN(sdi),
    .PRESET_PIN_B_IN(preset_b),
    .SPI_SDO_OUT(sdo),
    .SPI_SDO_OE_OUT(sdo_oe),
    .WIPER1_OUT(wiper1),
    .WIPER2_OUT(wiper2),
    .READ_POWER_OUT(read_power)
  );

  nvs_host host (
    .clk_in(clk),
    .sdo_in(sdo_wire),
    .cs_b_out(cs_b),
    .sclk_out(sclk),
    .sdi_out(sdi),
    .done_out(done),
    .rx_out(rx)
  );

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic go(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d,
                    input logic chk, input logic [23:0] erx);
    exp_q.push_back('{chk, erx, e_w1, e_w2, e_rp});
    host.frame({c, a, d}, 24);
  endtask

  task automatic cmd(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
    go(c, a, d, 1'b0, 24'h00_0000);
  endtask

  // A no-op frame clears read power and returns the word loaded by the last frame
  task automatic rd(input logic [23:0] erx);
    e_rp = 1'b0;
    go(CMD_NOP, ADDR_PRESET1, 16'h0000, 1'b1, erx);
  endtask

  always @(posedge done)
  begin
    nvs_exp_t e;
    checks_done++;
    if (exp_q.size() == 0)
    begin
      bad_count++;
      $display("CHECK FAILED %0t no note for result", $time);
    end
    else
    begin
      e = exp_q.pop_front();
      if (wiper1 !== e.w1 || wiper2 !== e.w2 || read_power !== e.rp || sdo_oe !== 1'b0 ||
          (e.chk && rx !== e.rx))
      begin
        bad_count++;
        $display("CHECK FAILED %0t w1 %h w2 %h rp %b rx %h", $time, wiper1, wiper2,
                 read_power, rx);
      end
    end
  end

  initial
  begin
    #300us;
    bad_count++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    end_of_test();
  end

  initial
  begin
    logic [3:0] ua[3];
    logic [15:0] d;
    ua = '{ADDR_USER_FIRST, ADDR_USER_SECOND, ADDR_USER_LAST};
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    repeat (20) @(negedge clk);
    rd(24'h00_0000);
    $display("test power-on done");
    e_w1 = WIPER_ZERO;
    cmd(CMD_WRITE_WIPER, ADDR_PRESET1, 16'h0000);
    e_w1 = WIPER_ONE;
    cmd(CMD_DOUBLE, ADDR_PRESET1, 16'h0000);
    cmd(CMD_WRITE_WIPER, ADDR_PRESET2, 16'h0200);
    e_w1 = 10'h002;
    e_w2 = WIPER_FULL;
    cmd(CMD_DOUBLE_ALL, ADDR_PRESET1, 16'h0000);
    e_w1 = 10'h2ab;
    cmd(CMD_WRITE_WIPER, ADDR_PRESET1, 16'h02ab);
    e_w1 = 10'h155;
    cmd(CMD_HALVE, ADDR_PRESET1, 16'h0000);
    e_w1 = 10'h0aa;
    e_w2 = 10'h1ff;
    cmd(CMD_HALVE_ALL, ADDR_PRESET1, 16'h0000);
    // Even code below midscale, so the later preset value 0x123 can never match it
    d = 16'($random(seed)) & 16'h01fe;
    e_w2 = d[WIPER_W-1:0];
    cmd(CMD_WRITE_WIPER, ADDR_PRESET2, d);
    e_w2 = {1'b0, d[WIPER_W-1:1]};
    cmd(CMD_HALVE, ADDR_PRESET2, 16'h0000);
    cmd(CMD_SAVE_WIPER, ADDR_PRESET2, 16'h0000);
    cmd(CMD_READ_STORE, ADDR_PRESET2, 16'h0000);
    rd({CMD_READ_STORE, ADDR_PRESET2, 6'h00, e_w2});
    $display("test shift steps done");
    for (int i = 0; i < 3; i++)
    begin
      d = 16'($random(seed));
      cmd(CMD_WRITE_STORE, ua[i], d);
      cmd(CMD_READ_STORE, ua[i], 16'h0000);
      rd({CMD_READ_STORE, ua[i], d});
    end
    cmd(CMD_WRITE_STORE, ADDR_TOLERANCE, 16'habcd);
    cmd(CMD_READ_STORE, ADDR_TOLERANCE, 16'h0000);
    // Default build holds a positive zero tolerance word
    rd({CMD_READ_STORE, ADDR_TOLERANCE, 16'h0000});
    $display("test store map done");
    exp_q.push_back('{1'b0, 24'h00_0000, e_w1, e_w2, e_rp});
    host.frame(24'hb0_0123, 20);
    cmd(CMD_WRITE_STORE, ADDR_PRESET1, 16'hfc55);
    e_w1 = 10'h055;
    e_rp = 1'b1;
    cmd(CMD_RESTORE, ADDR_PRESET1, 16'h0000);
    cmd(CMD_WRITE_STORE, ADDR_PRESET2, 16'h0123);
    e_w2 = 10'h123;
    cmd(CMD_RESTORE_ALL, ADDR_PRESET1, 16'h0000);
    rd(24'h80_0000);
    e_w2 = WIPER_ZERO;
    cmd(CMD_WRITE_WIPER, ADDR_PRESET2, 16'h0000);
    e_w2 = 10'h123;
    e_rp = 1'b1;
    cmd(CMD_RESTORE, ADDR_PRESET2, 16'h0000);
    rd(24'h11_0000);
    $display("test restore done");
    preset_b = 1'b0;
    e_w1 = WIPER_MID;
    e_w2 = WIPER_MID;
    rd(24'h00_0000);
    preset_b = 1'b1;
    e_w1 = 10'h055;
    e_w2 = 10'h123;
    rd(24'h00_0000);
    $display("test preset pin done");
    end_of_test();
  end
endmodule
